// *** logic/ccd_seq_pkg.sv ***
// Purpose: constants, modes and per-mode tables for the readout link
// Assumes: 50 MHz system clock, 1220 active rows, row 0 is array line 1
// Notes:   rates in millihertz keep frame lengths exact
package ccd_seq_pkg;

    typedef enum logic [3:0] {
        MODE_FULL   = 4'h0,
        MODE_DEC28  = 4'h1,
        MODE_DEC24  = 4'h2,
        MODE_ADD2   = 4'h3,
        MODE_CUT1   = 4'h4,
        MODE_CUT2   = 4'h5,
        MODE_CUT3   = 4'h6,
        MODE_FOCUS1 = 4'h7,
        MODE_FOCUS2 = 4'h8
    } readout_mode_type;

    localparam int          ROW_W        = 11;
    localparam logic [10:0] ACTIVE_ROWS  = 11'h4c4;
    localparam logic [10:0] ADD_SHIFT    = 11'h002;
    localparam logic [3:0]  DEC28_FIRST  = 4'h0;
    localparam logic [3:0]  DEC28_SECOND = 4'h5;
    localparam logic [3:0]  DEC24_FIRST  = 4'h2;
    localparam logic [3:0]  DEC24_SECOND = 4'h3;
    localparam logic [3:0]  GROUP_ONE    = 4'h1;
    localparam logic [3:0]  GROUP_FOUR   = 4'h4;
    localparam logic [3:0]  GROUP_EIGHT  = 4'h8;
    localparam logic [35:0] CLK_HZ_X1000 = 36'hba43b7400;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] group_size(input readout_mode_type m);
        case (m)
            MODE_FULL, MODE_CUT3:                 return GROUP_ONE;
            MODE_DEC28, MODE_FOCUS1, MODE_FOCUS2: return GROUP_EIGHT;
            default:                              return GROUP_FOUR;
        endcase
    endfunction

    function automatic logic two_per_group(input readout_mode_type m);
        return group_size(m) != GROUP_ONE;
    endfunction

    function automatic logic is_added(input readout_mode_type m);
        return (m == MODE_ADD2) || (m == MODE_CUT2);
    endfunction

    function automatic logic [3:0] ofs_first(input readout_mode_type m);
        return (group_size(m) == GROUP_EIGHT) ? DEC28_FIRST :
               (group_size(m) == GROUP_FOUR)  ? DEC24_FIRST : 4'h0;
    endfunction

    function automatic logic [3:0] ofs_second(input readout_mode_type m);
        return (group_size(m) == GROUP_EIGHT) ? DEC28_SECOND : DEC24_SECOND;
    endfunction

    // output lines per frame; fast means the 36 MHz drive
    function automatic logic [10:0] out_lines(input readout_mode_type m, input logic fast);
        case (m)
            MODE_FULL:   return 11'h4c4;
            MODE_DEC28:  return 11'h131;
            MODE_DEC24:  return 11'h262;
            MODE_ADD2:   return 11'h262;
            MODE_CUT1,
            MODE_CUT2:   return fast ? 11'h238 : 11'h1b2;
            MODE_CUT3:   return fast ? 11'h244 : 11'h1bc;
            MODE_FOCUS1: return fast ? 11'h0eb : 11'h0aa;
            MODE_FOCUS2: return fast ? 11'h04b : 11'h02b;
            default:     return 11'h000;
        endcase
    endfunction

    // rows covered by one output line
    function automatic logic [2:0] rows_per_line(input readout_mode_type m);
        return (group_size(m) == GROUP_ONE)  ? 3'h1 :
               (group_size(m) == GROUP_EIGHT) ? 3'h4 : 3'h2;
    endfunction

    // rows swept above the centre band, aligned to the readout group
    function automatic logic [10:0] sweep_rows(input readout_mode_type m, input logic fast);
        logic [13:0] used;
        logic [10:0] half;
        used = out_lines(m, fast) * rows_per_line(m);
        half = 11'((14'(ACTIVE_ROWS) - used) >> 1);
        return half & ~11'(group_size(m) - 4'h1);
    endfunction

    function automatic logic [19:0] rate_mhz(input readout_mode_type m, input logic fast);
        case (m)
            MODE_FULL:   return fast ? 20'h03a89 : 20'h02706;
            MODE_DEC28:  return 20'h07512;
            MODE_DEC24,
            MODE_ADD2:   return 20'h04e0c;
            MODE_FOCUS1: return 20'h0ea24;
            MODE_FOCUS2: return 20'h1d448;
            default:     return 20'h07512;
        endcase
    endfunction

    function automatic logic [31:0] frame_cycles(input readout_mode_type m, input logic fast);
        logic [35:0] q;
        q = CLK_HZ_X1000 / 36'(rate_mhz(m, fast));
        return q[31:0];
    endfunction

endpackage

// *** logic/ccd_link_if.sv ***
// Purpose: pulse link between the timing generator end and the sensor end
// Assumes: both ends run on the same clock; pulses last one clock-enabled cycle
// Notes:   the timing end holds mode steady for a frame
`timescale 1ns/1ps
`default_nettype none
interface ccd_link_if;
    logic                         readout_pulse;
    logic                         sweep_pulse;
    logic                         line_pulse;
    logic                         frame_end;
    ccd_seq_pkg::readout_mode_type mode;

    modport timing (
        output readout_pulse,
        output sweep_pulse,
        output line_pulse,
        output frame_end,
        output mode
    );

    modport sensor (
        input readout_pulse,
        input sweep_pulse,
        input line_pulse,
        input frame_end,
        input mode
    );
endinterface
`default_nettype wire

// *** logic/ccd_timing_end.sv ***
// Purpose: timing generator end: one frame of pulses per start request
// Assumes: start_i and mode_i synchronous to clock_i
// Notes:   a wait state pads each frame to the mode's rate
`timescale 1ns/1ps
`default_nettype none
module ccd_timing_end #(
    parameter int FRAME_SHIFT = 0
) (
    input  wire logic                          clock_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          clock_enable_i,
    input  wire logic                          start_i,
    input  wire ccd_seq_pkg::readout_mode_type mode_i,
    input  wire logic                          fast_clock_i,
    ccd_link_if.timing                         link,
    output logic                               busy_o,
    output logic                               frame_done_o
);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_READOUT = 3'b001,
        ST_SWEEP   = 3'b011,
        ST_LINES   = 3'b010,
        ST_WAIT    = 3'b110
    } timing_state_type;

    timing_state_type              state_reg;
    ccd_seq_pkg::readout_mode_type mode_reg;
    logic                          fast_reg;
    logic [10:0]                   cnt_reg;
    logic [31:0]                   frame_cnt_reg;

    ////////////////////////////////////////////////////////////////////////////
    wire logic [10:0] sweep_total = ccd_seq_pkg::sweep_rows(mode_reg, fast_reg);
    wire logic [10:0] line_total  = ccd_seq_pkg::out_lines(mode_reg, fast_reg);
    wire logic [31:0] frame_limit = ccd_seq_pkg::frame_cycles(mode_reg, fast_reg) >> FRAME_SHIFT;
    wire logic        sweep_last  = (cnt_reg + 11'h001) >= sweep_total;
    wire logic        lines_last  = (cnt_reg + 11'h001) >= line_total;
    wire logic        frame_over  = (frame_cnt_reg + 32'h0000_0001) >= frame_limit;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg          <= ST_IDLE;
            mode_reg           <= ccd_seq_pkg::MODE_FULL;
            fast_reg           <= 1'b0;
            cnt_reg            <= 11'h000;
            frame_cnt_reg      <= 32'h0000_0000;
            link.readout_pulse <= 1'b0;
            link.sweep_pulse   <= 1'b0;
            link.line_pulse    <= 1'b0;
            link.frame_end     <= 1'b0;
            link.mode          <= ccd_seq_pkg::MODE_FULL;
            busy_o             <= 1'b0;
            frame_done_o       <= 1'b0;
        end else if (clock_enable_i) begin
            link.readout_pulse <= 1'b0;
            link.sweep_pulse   <= 1'b0;
            link.line_pulse    <= 1'b0;
            link.frame_end     <= 1'b0;
            frame_done_o       <= 1'b0;
            frame_cnt_reg      <= frame_cnt_reg + 32'h0000_0001;
            case (state_reg)
                ST_IDLE: begin
                    if (start_i) begin
                        // mode only changes here, between frames
                        mode_reg           <= mode_i;
                        link.mode          <= mode_i;
                        fast_reg           <= fast_clock_i;
                        link.readout_pulse <= 1'b1;
                        frame_cnt_reg      <= 32'h0000_0000;
                        cnt_reg            <= 11'h000;
                        busy_o             <= 1'b1;
                        state_reg          <= ST_READOUT;
                    end
                end
                ST_READOUT: begin
                    state_reg <= (sweep_total == 11'h000) ? ST_LINES : ST_SWEEP;
                end
                ST_SWEEP: begin
                    // top region swept at one row per cycle
                    link.sweep_pulse <= 1'b1;
                    cnt_reg          <= sweep_last ? 11'h000 : cnt_reg + 11'h001;
                    if (sweep_last) begin
                        state_reg <= ST_LINES;
                    end
                end
                ST_LINES: begin
                    link.line_pulse <= 1'b1;
                    cnt_reg         <= cnt_reg + 11'h001;
                    if (lines_last) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (cnt_reg != 11'h000) begin
                        link.frame_end <= 1'b1;
                        cnt_reg        <= 11'h000;
                    end
                    // pad the frame so the rate matches the mode
                    if (frame_over) begin
                        busy_o       <= 1'b0;
                        frame_done_o <= 1'b1;
                        state_reg    <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_o    <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// *** logic/ccd_sensor_end.sv ***
// Purpose: sensor end: maps link pulses to array rows
// Assumes: mode steady for a whole frame
// Notes:   row 0 is array line 1, a red row;
//          rows below the last line are not read
//
// Notes on behaviour
// - progressive mode outputs every row once, in order
// - all photosites transfer together before lines start
// - 2-of-8 mode reads lines 1 and 6 of eight
// - 2-of-8 output starts with array line 1
// - 2-of-4 mode reads lines 3 and 4 of four
// - addition reads 3,4, shifts two, adds 1,2
// - addition sums two rows of the same colour
// - centre cut one: 2-of-4 after a top sweep
// - centre cut two: addition after a top sweep
// - centre cuts one and two near thirty frames
// - centre cut three: progressive rows after sweeping
// - focus one: 2-of-8 over a 940-row band at 36 MHz, 680 rows at 28.6364 MHz
// - focus two: 2-of-8 over a 300-row band at 36 MHz, 172 rows at 28.6364 MHz
// - each row tagged with its Bayer colour pair
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_end (
    input  wire logic                     clock_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     clock_enable_i,
    ccd_link_if.sensor                    link,
    output logic                          line_valid_o,
    output logic [ccd_seq_pkg::ROW_W-1:0] row_first_o,
    output logic [ccd_seq_pkg::ROW_W-1:0] row_second_o,
    output logic                          added_o,
    output logic                          green_beside_blue_row_o,
    output logic                          frame_active_o,
    output logic                          mode_error_o,
    output logic                          overrun_o
);

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_HELD   = 2'b01,
        ST_OUTPUT = 2'b11
    } sensor_state_type;

    sensor_state_type              state_reg;
    ccd_seq_pkg::readout_mode_type mode_reg;
    logic [10:0]                   ptr_reg;
    logic                          phase_reg;

    ////////////////////////////////////////////////////////////////////////////
    // row selection for the current step
    ////////////////////////////////////////////////////////////////////////////
    wire logic        in_frame  = (state_reg != ST_IDLE);
    wire logic        two_lines = ccd_seq_pkg::two_per_group(mode_reg);
    wire logic        add_lines = ccd_seq_pkg::is_added(mode_reg);
    wire logic [3:0]  ofs_a     = ccd_seq_pkg::ofs_first(mode_reg);
    wire logic [3:0]  ofs_b     = ccd_seq_pkg::ofs_second(mode_reg);
    wire logic [3:0]  step      = ccd_seq_pkg::group_size(mode_reg);

    // 2-of-8 offset 0 is array line 1
    wire logic [3:0]  ofs_sel   = (two_lines && phase_reg) ? ofs_b : ofs_a;
    wire logic [10:0] row_a     = ptr_reg + {7'h00, ofs_sel};

    // added rows sit two apart, so they always share a colour
    wire logic [10:0] row_b     = add_lines ? row_a - ccd_seq_pkg::ADD_SHIFT : row_a;
    wire logic        group_end = !two_lines || phase_reg;
    wire logic [10:0] ptr_adv   = ptr_reg + {7'h00, step};
    wire logic        row_fits  = row_a < ccd_seq_pkg::ACTIVE_ROWS;

    ////////////////////////////////////////////////////////////////////////////
    // accepted events
    ////////////////////////////////////////////////////////////////////////////
    wire logic line_take  = in_frame && link.line_pulse;
    wire logic sweep_take = in_frame && link.sweep_pulse;
    wire logic line_stray = !in_frame && (link.line_pulse || link.sweep_pulse);
    wire logic mode_moved = in_frame && (link.mode != mode_reg);
    wire logic mode_fault = mode_moved || line_stray;
    wire logic row_fault  = line_take && !row_fits;

    ////////////////////////////////////////////////////////////////////////////
    // frame state, pointer and phase
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            mode_reg  <= ccd_seq_pkg::MODE_FULL;
            ptr_reg   <= 11'h000;
            phase_reg <= 1'b0;
        end else if (clock_enable_i) begin
            case (state_reg)
                ST_IDLE: begin
                    if (link.readout_pulse) begin
                        // all rows captured at once; restart at line 1
                        mode_reg  <= link.mode;
                        ptr_reg   <= 11'h000;
                        phase_reg <= 1'b0;
                        state_reg <= ST_HELD;
                    end
                end
                ST_HELD, ST_OUTPUT: begin
                    if (link.frame_end) begin
                        state_reg <= ST_IDLE;
                    end else if (sweep_take) begin
                        // high-speed transfer discards one row
                        ptr_reg <= ptr_reg + 11'h001;
                    end else if (line_take) begin
                        state_reg <= ST_OUTPUT;
                        phase_reg <= two_lines && !phase_reg;
                        if (group_end) begin
                            ptr_reg <= ptr_adv;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // line output; a row past the array is dropped rather than wrapped
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            line_valid_o            <= 1'b0;
            row_first_o             <= 11'h000;
            row_second_o            <= 11'h000;
            added_o                 <= 1'b0;
            green_beside_blue_row_o <= 1'b0;
        end else if (clock_enable_i) begin
            line_valid_o <= line_take && row_fits && !link.frame_end;
            if (line_take && row_fits) begin
                row_first_o             <= row_a;
                row_second_o            <= row_b;
                added_o                 <= add_lines;
                // odd rows: green_beside_blue and blue
                green_beside_blue_row_o <= row_a[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status; error flags hold until the next readout pulse
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_active_o <= 1'b0;
            mode_error_o   <= 1'b0;
            overrun_o      <= 1'b0;
        end else if (clock_enable_i) begin
            if (state_reg == ST_IDLE && link.readout_pulse) begin
                frame_active_o <= 1'b1;
            end else if (link.frame_end) begin
                frame_active_o <= 1'b0;
            end
            // a fault in the readout cycle wins
            if (mode_fault) begin
                mode_error_o <= 1'b1;
            end else if (state_reg == ST_IDLE && link.readout_pulse) begin
                mode_error_o <= 1'b0;
            end
            if (row_fault) begin
                overrun_o <= 1'b1;
            end else if (state_reg == ST_IDLE && link.readout_pulse) begin
                overrun_o <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** verif/ccd_link_properties.sv ***
// Purpose: concurrent checks on the timing-to-sensor pulse link
// Assumes: clock enable high, so each pulse lasts one cycle
// Notes:   line totals accept either drive rate; the link does not carry it
`timescale 1ns/1ps
`default_nettype none
module ccd_link_properties (
    input wire logic                          clock_i,
    input wire logic                          reset_n_i,
    input wire logic                          readout_pulse,
    input wire logic                          sweep_pulse,
    input wire logic                          line_pulse,
    input wire logic                          frame_end,
    input wire ccd_seq_pkg::readout_mode_type mode
);
    localparam logic [10:0] FRAME_MAX = 11'h514;
    logic        in_frame_reg;
    logic [10:0] line_cnt_reg;
    logic [10:0] frame_age_reg;
    logic [21:0] lines_pair;

    // upper half 36 MHz count, lower half 28.6364 MHz
    function automatic logic [21:0] pair_of(input logic [3:0] m);
        case (m)
            4'h0:       return {11'h4c4, 11'h4c4};
            4'h1:       return {11'h131, 11'h131};
            4'h2, 4'h3: return {11'h262, 11'h262};
            4'h4, 4'h5: return {11'h238, 11'h1b2};
            4'h6:       return {11'h244, 11'h1bc};
            4'h7:       return {11'h0eb, 11'h0aa};
            default:    return {11'h04b, 11'h02b};
        endcase
    endfunction

    assign lines_pair = pair_of(mode);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_frame_reg <= 1'b0;
            line_cnt_reg <= 11'h000;
            frame_age_reg <= 11'h000;
        end else begin
            in_frame_reg <= readout_pulse | (in_frame_reg & ~frame_end);
            line_cnt_reg <= readout_pulse ? 11'h000 : line_cnt_reg + 11'(line_pulse);
            frame_age_reg <= readout_pulse ? 11'h000 : frame_age_reg + 11'(in_frame_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    chk_readout_alone: assert property (
        readout_pulse |=> !(readout_pulse || sweep_pulse || line_pulse))
        else $error("no quiet cycle after readout");
    chk_readout_idle: assert property (
        readout_pulse |-> !in_frame_reg)
        else $error("readout inside a frame");
    chk_mode_steady: assert property (
        in_frame_reg |-> $stable(mode))
        else $error("mode changed mid-frame");
    chk_line_in_frame: assert property (
        line_pulse |-> in_frame_reg)
        else $error("line outside a frame");
    chk_sweep_first: assert property (
        sweep_pulse |-> in_frame_reg && line_cnt_reg == 11'h000)
        else $error("sweep after lines");
    chk_line_total: assert property (
        frame_end |-> line_cnt_reg == lines_pair[21:11] || line_cnt_reg == lines_pair[10:0])
        else $error("wrong line count");
    chk_pulse_onehot: assert property (
        $onehot0({readout_pulse, sweep_pulse, line_pulse, frame_end}))
        else $error("two pulses in one cycle");
    chk_end_after_line: assert property (
        frame_end |-> in_frame_reg && $past(line_pulse))
        else $error("frame end not after last line");
    chk_frame_bounded: assert property (
        in_frame_reg |-> frame_age_reg < FRAME_MAX && (!frame_end || frame_age_reg > 11'h001))
        else $error("frame length out of range");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: a faulty link, then every mode at both drive rates
// Assumes: 50 MHz clock, frame padding shortened by FRAME_SHIFT of 12
// Notes:   expected values come from the mode tables only
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock_i;
    logic reset_n_i    = 1'b0;
    logic clock_enable = 1'b1;
    logic start        = 1'b0;
    logic fast         = 1'b0;
    logic busy, frame_done, line_valid, added, gb_row, frame_active, mode_error, overrun;
    logic bad_error;
    logic [10:0] row_first, row_second, er;
    int   err_total = 0;
    int   cmp_count = 0;
    int   line_idx, sweeps, readouts;
    logic cur_fast = 1'b0;
    logic exp_add  = 1'b0;
    ccd_seq_pkg::readout_mode_type mode_sel = ccd_seq_pkg::MODE_FULL;
    ccd_seq_pkg::readout_mode_type cur_mode = ccd_seq_pkg::MODE_FULL;

    ccd_link_if ccd_link_if_i ();
    ccd_link_if fault_link_i ();
    ccd_timing_end #(.FRAME_SHIFT(12)) ccd_timing_end_i (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .clock_enable_i(clock_enable), .start_i(start),
        .mode_i(mode_sel), .fast_clock_i(fast), .link(ccd_link_if_i.timing),
        .busy_o(busy), .frame_done_o(frame_done));
    ccd_sensor_end ccd_sensor_end_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .clock_enable_i(clock_enable), .link(ccd_link_if_i.sensor), .line_valid_o(line_valid),
        .row_first_o(row_first), .row_second_o(row_second), .added_o(added),
        .green_beside_blue_row_o(gb_row), .frame_active_o(frame_active),
        .mode_error_o(mode_error), .overrun_o(overrun));
    // bench-driven sensor end for provoked link faults
    ccd_sensor_end fault_sensor_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .clock_enable_i(clock_enable), .link(fault_link_i.sensor), .line_valid_o(),
        .row_first_o(), .row_second_o(), .added_o(), .green_beside_blue_row_o(),
        .frame_active_o(), .mode_error_o(bad_error), .overrun_o());
    ccd_link_properties ccd_link_properties_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .readout_pulse(ccd_link_if_i.readout_pulse), .sweep_pulse(ccd_link_if_i.sweep_pulse),
        .line_pulse(ccd_link_if_i.line_pulse), .frame_end(ccd_link_if_i.frame_end),
        .mode(ccd_link_if_i.mode));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] lines_of(input logic [3:0] m, input logic f);
        case (m)
            4'h0:       return 11'h4c4;
            4'h1:       return 11'h131;
            4'h2, 4'h3: return 11'h262;
            4'h4, 4'h5: return f ? 11'h238 : 11'h1b2;
            4'h6:       return f ? 11'h244 : 11'h1bc;
            4'h7:       return f ? 11'h0eb : 11'h0aa;
            default:    return f ? 11'h04b : 11'h02b;
        endcase
    endfunction

    function automatic logic [3:0] grp_of(input logic [3:0] m);
        return (m == 4'h0 || m == 4'h6) ? 4'h1 : (m == 4'h1 || m > 4'h6) ? 4'h8 : 4'h4;
    endfunction

    // top sweep: half the unread rows, down to a whole group
    function automatic logic [10:0] sweep_of(input logic [3:0] m, input logic f);
        logic [3:0]  g;
        logic [13:0] used;
        g = grp_of(m);
        used = lines_of(m, f) * ((g == 4'h1) ? 14'h0001 : 14'(g >> 1));
        return 11'((14'h04c4 - used) >> 1) & ~11'(g - 4'h1);
    endfunction

    function automatic logic [10:0] exp_row(input int j);
        logic [3:0]  g;
        logic [10:0] base;
        g = grp_of(cur_mode);
        base = sweep_of(cur_mode, cur_fast);
        if (g == 4'h1) return base + 11'(j);
        base = base + 11'(j / 2) * 11'(g);
        if (j % 2 == 1) return base + ((g == 4'h8) ? 11'h005 : 11'h003);
        return base + ((g == 4'h8) ? 11'h000 : 11'h002);
    endfunction

    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        if (ccd_link_if_i.sweep_pulse === 1'b1) sweeps++;
        if (ccd_link_if_i.readout_pulse === 1'b1) readouts++;
        if (line_valid === 1'b1) begin
            er = exp_row(line_idx);
            chk(row_first, er, "row read");
            chk(row_second, exp_add ? er - 11'h002 : er, "partner");
            chk(11'(added), 11'(exp_add), "added");
            chk(11'(gb_row), 11'(er[0]), "colour row");
            line_idx++;
        end
    end

    // start held and mode_i changed mid-frame (left unchanged for mode 4): both refused
    task automatic run_frame(input logic [3:0] m, input logic f);
        int n;
        cur_mode = ccd_seq_pkg::readout_mode_type'(m);
        cur_fast = f;
        exp_add = (m == 4'h3) || (m == 4'h5);
        line_idx = 0;
        sweeps = 0;
        readouts = 0;
        mode_sel = cur_mode;
        fast = f;
        start = 1'b1;
        tick();
        mode_sel = ccd_seq_pkg::readout_mode_type'(4'h8 - m);
        repeat (4) tick();
        chk(11'({busy, frame_active}), 11'h003, "frame started");
        start = 1'b0;
        n = 0;
        while (frame_done !== 1'b1 && n < 4000) begin
            tick();
            n++;
        end
        tick();
        chk(11'(n < 4000), 11'h001, "frame done");
        chk(11'(line_idx), lines_of(m, f), "line count");
        chk(11'(sweeps), sweep_of(m, f), "sweep count");
        chk(11'(readouts), 11'h001, "readouts");
        chk({7'h00, busy, frame_active, mode_error, overrun}, 11'h000, "end flags");
    endtask

    task automatic fault_link();
        fault_link_i.readout_pulse = 1'b1;
        tick();
        fault_link_i.readout_pulse = 1'b0;
        fault_link_i.mode = ccd_seq_pkg::MODE_DEC24;
        repeat (2) tick();
        chk(11'(bad_error), 11'h001, "mode change flag");
        fault_link_i.frame_end = 1'b1;
        tick();
        fault_link_i.frame_end = 1'b0;
        fault_link_i.readout_pulse = 1'b1;
        tick();
        fault_link_i.readout_pulse = 1'b0;
        fault_link_i.frame_end = 1'b1;
        tick();
        fault_link_i.frame_end = 1'b0;
        chk(11'(bad_error), 11'h000, "flag cleared");
        fault_link_i.line_pulse = 1'b1;
        tick();
        fault_link_i.line_pulse = 1'b0;
        repeat (2) tick();
        chk(11'(bad_error), 11'h001, "stray line flag");
    endtask

    initial begin
        fault_link_i.readout_pulse = 1'b0;
        fault_link_i.sweep_pulse = 1'b0;
        fault_link_i.line_pulse = 1'b0;
        fault_link_i.frame_end = 1'b0;
        fault_link_i.mode = ccd_seq_pkg::MODE_FULL;
        repeat (20) @(posedge clock_i);
        #1;
        reset_n_i = 1'b1;
        fault_link();
        for (int m = 0; m < 9; m++) begin
            for (int f = 0; f < 2; f++) begin
                run_frame(4'(m), 1'(f));
            end
        end
        give_verdict();
    end

    // run is near 12k cycles; cut a hang at 100k
    initial begin
        #2000000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
